// [rtl/status_query_responder.sv]
// Status query responder: formats query replies into a byte stream.
// Assumes measurements are synchronous inputs and software drives AXI4-Lite.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module status_query_responder
   import sqr_pkg::*;
(
   input  wire logic                      aclk,          // Clock
   input  wire logic                      aresetn,       // Sync reset, low
   input  wire logic                      awvalid,       // Write address valid
   output logic                           awready,       // Write address ready
   input  wire logic [sqr_pkg::ADDR_W-1:0] awaddr,       // Write address
   input  wire logic                      wvalid,        // Write data valid
   output logic                           wready,        // Write data ready
   input  wire logic [31:0]               wdata,         // Write data
   input  wire logic [3:0]                wstrb,         // Write strobes
   output logic                           bvalid,        // Write resp valid
   input  wire logic                      bready,        // Write resp ready
   output logic [1:0]                     bresp,         // Write response
   input  wire logic                      arvalid,       // Read address valid
   output logic                           arready,       // Read address ready
   input  wire logic [sqr_pkg::ADDR_W-1:0] araddr,       // Read address
   output logic                           rvalid,        // Read data valid
   input  wire logic                      rready,        // Read data ready
   output logic [31:0]                    rdata,         // Read data
   output logic [1:0]                     rresp,         // Read response
   input  wire logic                      last_rate_data,  // Rate kept
   input  wire logic [7:0]                major1_in,     // Major alarms 1
   input  wire logic [7:0]                major2_in,     // Major alarms 2
   input  wire logic [7:0]                minor1_in,     // Minor alarms 1
   input  wire logic [7:0]                minor2_in,     // Minor alarms 2
   input  wire logic [7:0]                common_in,     // Common faults
   input  wire logic [7:0]                volt_p5,       // +5 V, tenths
   input  wire logic [7:0]                volt_p12,      // +12 V, tenths
   input  wire logic [7:0]                volt_n12_mag,  // -12 V magnitude
   input  wire logic [7:0]                volt_p24,      // +24 V, tenths
   input  wire logic signed [15:0]        input_level,   // dBm
   input  wire logic [31:0]               freq_offset,   // Hz, signed
   input  wire logic [31:0]               symb_offset,   // Hz, signed
   input  wire logic [15:0]               ebno_est,      // 0.01 dB
   input  wire logic [15:0]               est_ber_mant,  // Mantissa x100
   input  wire logic signed [15:0]        est_ber_exp,   // Exponent
   input  wire logic [15:0]               tp_ber_mant,   // Mantissa x100
   input  wire logic signed [15:0]        tp_ber_exp,    // Exponent
   input  wire logic [63:0]               tp_err_count,  // Pattern errors
   input  wire logic [31:0]               tp_run_time,   // Seconds
   input  wire logic                      outer_ber_ok,  // Outer ratio valid
   input  wire logic                      tp_ber_ok,     // Pattern ratio ok
   input  wire logic [7:0]                buf_fill,      // Percent
   input  wire sqr_pkg::ebno_qual_t       ebno_qual,     // Eb/No qualifier
   input  wire logic                      stream_cont,   // Continuous bytes
   input  wire logic                      early_sync_loss, // Early loss
   input  wire logic                      tp_inverted,   // Inverted pattern
   input  wire logic [7:0]                hour,          // 0..23
   input  wire logic [7:0]                minute,        // 0..59
   input  wire logic [7:0]                second,        // 0..59
   input  wire logic [7:0]                year,          // 0..99
   input  wire logic [7:0]                month,         // 0..11
   input  wire logic [7:0]                day,           // 0..30
   input  wire logic [63:0]               local_mac,     // Local hw address
   input  wire logic [31:0]               local_ip,      // Local net address
   input  wire logic [14:0]               local_port,    // Local port
   input  wire logic [63:0]               dest_mac,      // Dest hw address
   input  wire logic [31:0]               dest_ip,       // Dest net address
   input  wire logic [15:0]               dest_port,     // Dest port
   input  wire sqr_pkg::eth_mode_t        eth_mode,      // Ethernet mode
   input  wire logic                      not_aligned,   // Block not aligned
   input  wire logic [7:0]                fec_cols_l,    // FEC dimension L
   input  wire logic [7:0]                fec_cols_d,    // FEC dimension D
   input  wire logic [2:0]                port_state,    // Port state code
   input  wire logic [31:0]               total_pkts,    // Total packets
   input  wire logic [31:0]               fec_pkts,      // FEC packets
   input  wire logic [127:0]              revision       // Revision field
);
   import sqr_pkg::*;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_CMD) || (a == ADDR_STAT) ||
             (a == ADDR_DATA) || (a == ADDR_LCLR);
   endfunction

   logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]          bresp_q, rresp_q;
   logic [31:0]         rdata_q;
   logic                aw_hold_q, w_hold_q;
   logic [ADDR_W-1:0]   awaddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                do_write, cmd_wr, lclr_wr, data_rd;
   logic [39:0]         cur_alarms, latched_q;
   logic [RESP_W-1:0]   resp_q, resp_d;
   logic [7:0]          len_q, len_d;
   logic                err_q, err_d;
   logic [16:0]         cmd_q;

   // Output ports come straight from flops
   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Write decode once address and data are both held
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign cmd_wr   = do_write && (awaddr_q == ADDR_CMD) &&
                     (wstrb_q[2:0] == 3'b111);
   assign lclr_wr  = do_write && (awaddr_q == ADDR_LCLR) && wstrb_q[0] &&
                     wdata_q[0];
   assign data_rd  = arvalid && arready_q && (araddr == ADDR_DATA);

   // Write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (awvalid && awready_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= awaddr;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
            wready_q <= 1'b0;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
               ADDR_CMD:  rdata_q <= {15'h0000, cmd_q};
               ADDR_STAT: rdata_q <= {23'h000000, err_q, len_q};
               ADDR_DATA: rdata_q <= {24'h000000,
                             (len_q != LEN_RST) ?
                             resp_q[RESP_W-1 -: 8] : 8'h00};
               default:   rdata_q <= '0;
            endcase
         end
         if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Current alarms with reserved bits forced to zero
   assign cur_alarms = {major1_in & MAJ1_MASK,
                        major2_in & MAJ2_MASK,
                        minor1_in & MIN1_MASK,
                        minor2_in & MIN2_MASK,
                        common_in & COMM_MASK};

   // Latched alarms: a new alarm wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_q <= LATCH_RST;
      end else begin
         latched_q <= (lclr_wr ? LATCH_RST : latched_q) | cur_alarms;
      end
   end

   // Reply formatter, first byte in the top bits
   always_comb begin
      resp_d = '0;
      len_d  = LEN_RST;
      err_d  = 1'b0;
      unique case (wdata_q[15:0])
         OP_STATUS: begin
            resp_d = {7'h00, last_rate_data,
                      cur_alarms, latched_q,
                      volt_p5, volt_p12,
                      volt_n12_mag,
                      volt_p24,
                      input_level,
                      freq_offset, symb_offset,
                      ebno_est,
                      est_ber_mant, est_ber_exp,
                      tp_ber_mant, tp_ber_exp,
                      tp_err_count, tp_run_time,
                      6'h00, tp_ber_ok, outer_ber_ok,
                      buf_fill,
                      6'h00, ebno_qual,
                      7'h00, stream_cont,
                      7'h00, early_sync_loss,
                      7'h00, tp_inverted};
            len_d  = LEN_STATUS;
         end
         OP_ALARMS: begin
            resp_d = {wdata_q[CMD_LATCH_BIT] ? latched_q : cur_alarms,
                      {(RESP_W-40){1'b0}}};
            len_d  = LEN_ALARMS;
         end
         OP_TIME: begin
            resp_d = {hour, minute, second, {(RESP_W-24){1'b0}}};
            len_d  = LEN_TIME;
         end
         OP_DATE: begin
            resp_d = {year, month, day, {(RESP_W-24){1'b0}}};
            len_d  = LEN_DATE;
         end
         OP_ETH_CFG: begin
            resp_d = {local_mac, local_ip, 1'b0, local_port,
                      dest_mac, dest_ip, dest_port,
                      6'h00, eth_mode, 7'h00, not_aligned,
                      fec_cols_l, fec_cols_d,
                      {(RESP_W-256){1'b0}}};
            len_d  = LEN_ETH_CFG;
         end
         OP_ETH_STAT: begin
            resp_d = {5'h00, port_state, total_pkts, fec_pkts,
                      revision, {(RESP_W-200){1'b0}}};
            len_d  = LEN_ETH_STAT;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   // Reply buffer: loaded by a command, shifted out one byte per data read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_q <= '0;
         len_q  <= LEN_RST;
         err_q  <= 1'b0;
         cmd_q  <= '0;
      end else if (cmd_wr) begin
         resp_q <= resp_d;
         len_q  <= len_d;
         err_q  <= err_d;
         cmd_q  <= wdata_q[16:0];
      end else if (data_rd && (len_q != LEN_RST)) begin
         resp_q <= {resp_q[RESP_W-9:0], 8'h00};
         len_q  <= len_q - 8'h01;
      end
   end

   // Checks on the formatted replies, the alarm latch and the read channel
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence cmd_s(logic [15:0] op);
      cmd_wr && (wdata_q[15:0] == op);
   endsequence

   time_reply_a: assert property (cmd_s(OP_TIME) |=>
      len_q == LEN_TIME && resp_q[RESP_W-1 -: 24] ==
      {$past(hour), $past(minute), $past(second)})
      else $error("time reply wrong");
   date_reply_a: assert property (cmd_s(OP_DATE) |=>
      len_q == LEN_DATE && resp_q[RESP_W-9 -: 8] == $past(month))
      else $error("date reply wrong");
   status_len_a: assert property (cmd_s(OP_STATUS) |=>
      len_q == LEN_STATUS && resp_q[RESP_W-105 -: 8] == $past(volt_n12_mag))
      else $error("status reply wrong");
   alarm_rsvd_a: assert property (cmd_s(OP_ALARMS) |=>
      len_q == LEN_ALARMS &&
      (resp_q[RESP_W-1 -: 8] & ~MAJ1_MASK) == 8'h00 &&
      (resp_q[RESP_W-9 -: 8] & ~MAJ2_MASK) == 8'h00 &&
      (resp_q[RESP_W-17 -: 8] & ~MIN1_MASK) == 8'h00 &&
      (resp_q[RESP_W-33 -: 8] & ~COMM_MASK) == 8'h00)
      else $error("alarm reserved bit set");
   latch_set_a: assert property (major2_in[0] |=>
      latched_q[24] ##1 (latched_q[24] || $past(lclr_wr)))
      else $error("alarm not latched");
   pop_order_a: assert property (data_rd && len_q > 8'h01 && !cmd_wr |=>
      len_q == $past(len_q) - 8'h01 &&
      resp_q[RESP_W-1 -: 8] == $past(resp_q[RESP_W-9 -: 8]))
      else $error("byte order broken");
   port_limit_a: assert property (cmd_s(OP_ETH_CFG) |=>
      len_q == LEN_ETH_CFG && !resp_q[RESP_W-97])
      else $error("port above limit");
   eth_stat_a: assert property (cmd_s(OP_ETH_STAT) |=>
      len_q == LEN_ETH_STAT && resp_q[RESP_W-1 -: 5] == 5'h00)
      else $error("port state byte wrong");
   read_ans_a: assert property (arvalid && arready_q |=>
      rvalid_q [*1] ##0 !arready_q)
      else $error("read answer late");
endmodule // status_query_responder

`default_nettype wire

// [rtl/sqr_pkg.sv]
// Constants, opcodes and register map of the status query responder.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package sqr_pkg;
   // Response buffer size: the longest reply is the status reply
   localparam int unsigned RESP_BYTES = 53;
   localparam int unsigned RESP_W     = RESP_BYTES * 8;
   localparam int unsigned ADDR_W     = 8;

   // Query opcodes
   localparam logic [15:0] OP_STATUS   = 16'h240C;
   localparam logic [15:0] OP_ALARMS   = 16'h2406;
   localparam logic [15:0] OP_TIME     = 16'h240E;
   localparam logic [15:0] OP_DATE     = 16'h240F;
   localparam logic [15:0] OP_ETH_CFG  = 16'h2550;
   localparam logic [15:0] OP_ETH_STAT = 16'h2551;

   // Reply lengths in bytes
   localparam logic [7:0] LEN_STATUS   = 8'h35;
   localparam logic [7:0] LEN_ALARMS   = 8'h05;
   localparam logic [7:0] LEN_TIME     = 8'h03;
   localparam logic [7:0] LEN_DATE     = 8'h03;
   localparam logic [7:0] LEN_ETH_CFG  = 8'h20;
   localparam logic [7:0] LEN_ETH_STAT = 8'h19;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CMD  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_LCLR = 8'h0C;

   // Command and status word fields
   localparam int unsigned CMD_LATCH_BIT = 16;
   localparam int unsigned STAT_ERR_BIT  = 8;

   // Implemented bits of each alarm byte
   localparam logic [7:0] MAJ1_MASK = 8'h97;
   localparam logic [7:0] MAJ2_MASK = 8'h03;
   localparam logic [7:0] MIN1_MASK = 8'h7E;
   localparam logic [7:0] MIN2_MASK = 8'hFF;
   localparam logic [7:0] COMM_MASK = 8'h6F;

   // Reset values
   localparam logic [39:0] LATCH_RST = 40'h00_0000_0000;
   localparam logic [7:0]  LEN_RST   = 8'h00;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {ETH_UDP, ETH_COP3, ETH_COP3_FEC} eth_mode_t;
   typedef enum logic [1:0] {EBNO_INVALID, EBNO_VALID, EBNO_BELOW,
                             EBNO_ABOVE} ebno_qual_t;
endpackage

// [verif/axi_host.sv]
// AXI4-Lite host model that stands where the remote host would.
// Assumes its tasks are entered just after a rising edge of aclk.
`timescale 1ns/10ps
`default_nettype none
module axi_host
   import sqr_pkg::*;
(
   input  wire logic                       aclk,    // Clock
   output logic                            awvalid, // Write address valid
   input  wire logic                       awready, // Write address ready
   output logic [sqr_pkg::ADDR_W-1:0]      awaddr,  // Write address
   output logic                            wvalid,  // Write data valid
   input  wire logic                       wready,  // Write data ready
   output logic [31:0]                     wdata,   // Write data
   output logic [3:0]                      wstrb,   // Write strobes
   input  wire logic                       bvalid,  // Write resp valid
   output logic                            bready,  // Write resp ready
   input  wire logic [1:0]                 bresp,   // Write response
   output logic                            arvalid, // Read address valid
   input  wire logic                       arready, // Read address ready
   output logic [sqr_pkg::ADDR_W-1:0]      araddr,  // Read address
   input  wire logic                       rvalid,  // Read data valid
   output logic                            rready,  // Read data ready
   input  wire logic [31:0]                rdata,   // Read data
   input  wire logic [1:0]                 rresp    // Read response
);
   // Idle bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
   end
   // One write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // One read: address held until taken, rready held until rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // axi_host
`default_nettype wire

// [verif/status_query_responder_tb.sv]
// Testbench of the status query responder: queries and byte replies.
// Assumes the host model in axi_host and the design's package.
`timescale 1ns/10ps
`default_nettype none
module status_query_responder_tb;
   import sqr_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, last_rate_data, outer_ber_ok, tp_ber_ok;
   logic stream_cont, early_sync_loss, tp_inverted, not_aligned;
   logic [7:0] awaddr, araddr, major1_in, major2_in, minor1_in, minor2_in;
   logic [7:0] common_in, volt_p5, volt_p12, volt_n12_mag, volt_p24;
   logic [7:0] buf_fill, hour, minute, second, year, month, day;
   logic [7:0] fec_cols_l, fec_cols_d;
   logic [31:0] wdata, rdata, freq_offset, symb_offset, tp_run_time;
   logic [31:0] local_ip, dest_ip, total_pkts, fec_pkts;
   logic [15:0] input_level, ebno_est, est_ber_mant, est_ber_exp;
   logic [15:0] tp_ber_mant, tp_ber_exp, dest_port;
   logic [63:0] tp_err_count, local_mac, dest_mac;
   logic [127:0] revision;
   logic [14:0] local_port;
   logic [3:0] wstrb;
   logic [2:0] port_state;
   logic [1:0] bresp, rresp;
   ebno_qual_t ebno_qual;
   eth_mode_t eth_mode;
   logic [7:0] exp_q[$];
   int errors = 0;
   int compares = 0;

   status_query_responder DUT (.*);
   axi_host host (.*);

   // Free-running 125 MHz clock
   always #4 aclk = ~aclk;

   // Compares one result and reports a mismatch
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Queues n bytes of v, most significant first
   task automatic put(input logic [127:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[i*8 +: 8]);
   endtask
   // Issues a query and drains the reply against the queue
   task automatic run_query(input logic [15:0] op, input logic lt);
      logic [31:0] d;
      logic [1:0] r;
      host.wr(ADDR_CMD, {15'h0000, lt, op}, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY));
      host.rd(ADDR_STAT, d, r);
      chk(32'(d[8:0]), 32'(exp_q.size()));
      while (exp_q.size() > 0) begin
         host.rd(ADDR_DATA, d, r);
         chk(32'(d[7:0]), 32'(exp_q.pop_front()));
      end
      host.rd(ADDR_DATA, d, r);
      chk(32'(d[7:0]), 32'h00000000);
   endtask
   // Drives all five alarm inputs
   task automatic alarms(input logic [39:0] v);
      {major1_in, major2_in, minor1_in, minor2_in, common_in} <= v;
      @(posedge aclk);
   endtask

   // Time and date replies
   task automatic t_clock();
      {hour, minute, second} <= 24'h173B00;
      {year, month, day} <= 24'h630B1E;
      @(posedge aclk);
      put(24'h173B00, 3);
      run_query(OP_TIME, 1'b0);
      put(24'h630B1E, 3);
      run_query(OP_DATE, 1'b0);
   endtask
   // Latched and current alarms, reserved bits, clear
   task automatic t_alarm();
      logic [1:0] r;
      alarms(40'hFFFFFFFFFF);
      alarms(40'h0000000000);
      put(40'h97037EFF6F, 5);
      run_query(OP_ALARMS, 1'b1);
      alarms(40'h810240A120);
      put(40'h810240A120, 5);
      run_query(OP_ALARMS, 1'b0);
      alarms(40'h0000000000);
      put(40'h0000000000, 5);
      run_query(OP_ALARMS, 1'b0);
      host.wr(ADDR_LCLR, 32'h00000001, 4'h1, r);
      chk(32'(r), 32'(RESP_OKAY));
      put(40'h0000000000, 5);
      run_query(OP_ALARMS, 1'b1);
   endtask
   // Status reply over all qualifier codes
   task automatic t_status();
      for (int q = 0; q < 4; q++) begin
         {last_rate_data, early_sync_loss} <= {q[1], q[1]};
         {outer_ber_ok, tp_ber_ok} <= {q[0], q[1]};
         {stream_cont, tp_inverted} <= {q[0], q[0]};
         ebno_qual <= ebno_qual_t'(q);
         {volt_p5, volt_p12, volt_n12_mag, volt_p24} <= 32'h31767AF5;
         {input_level, ebno_est} <= {16'hFFCE, 16'h0406};
         {freq_offset, symb_offset} <= {32'hFFFFFF00, 32'h00001234};
         {est_ber_mant, est_ber_exp} <= {16'h01ED, 16'hFFFA};
         {tp_ber_mant, tp_ber_exp} <= {16'h0102, 16'h8001};
         tp_err_count <= 64'h0102030405060708;
         {tp_run_time, buf_fill} <= {32'hA1B2C3D4, 8'h64};
         @(posedge aclk);
         put(last_rate_data, 1);
         put(80'h0, 10);
         put(32'h31767AF5, 4);
         put({16'hFFCE, 32'hFFFFFF00, 32'h00001234, 16'h0406}, 12);
         put({16'h01ED, 16'hFFFA, 16'h0102, 16'h8001}, 8);
         put({64'h0102030405060708, 32'hA1B2C3D4}, 12);
         put({6'h00, q[1], q[0], 8'h64, 6'h00, q[1:0]}, 3);
         put({7'h00, q[0], 7'h00, q[1], 7'h00, q[0]}, 3);
         run_query(OP_STATUS, 1'b0);
      end
   endtask
   // Ethernet configuration for each mode, then Ethernet status
   task automatic t_eth();
      for (int m = 0; m < 3; m++) begin
         {local_mac, local_ip} <= {64'h0011223344556677, 32'hC0A80001};
         {dest_mac, dest_ip} <= {64'h8899AABBCCDDEEFF, 32'h0A000002};
         {local_port, dest_port} <= {15'h7FFF, 16'hFFFF};
         eth_mode <= eth_mode_t'(m);
         not_aligned <= m[0];
         {fec_cols_l, fec_cols_d} <= 16'h0A05;
         @(posedge aclk);
         put({64'h0011223344556677, 32'hC0A80001, 16'h7FFF}, 14);
         put({64'h8899AABBCCDDEEFF, 32'h0A000002, 16'hFFFF}, 14);
         put({6'h00, m[1:0], 7'h00, m[0], 16'h0A05}, 4);
         run_query(OP_ETH_CFG, 1'b0);
      end
      {port_state, total_pkts, fec_pkts} <= {3'h7, 32'h12345678, 32'h9A};
      revision <= 128'h000102030405060708090A0B0C0D0E0F;
      @(posedge aclk);
      put({8'h07, 32'h12345678, 32'h0000009A}, 9);
      put(128'h000102030405060708090A0B0C0D0E0F, 16);
      run_query(OP_ETH_STAT, 1'b0);
   endtask
   // Unknown opcode, empty reply read, unmapped address
   task automatic t_refuse();
      logic [31:0] d;
      logic [1:0] r;
      host.wr(ADDR_CMD, 32'h00001234, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY));
      host.rd(ADDR_STAT, d, r);
      chk(32'(d[8:0]), 32'h00000100);
      host.rd(ADDR_DATA, d, r);
      chk(d, 32'h00000000);
      host.rd(ADDR_CMD, d, r);
      chk(d, 32'h00001234);
      host.wr(8'h10, 32'h0000240E, 4'hF, r);
      chk(32'(r), 32'(RESP_SLVERR));
      host.rd(8'h10, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic tally_and_finish();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence: inputs at zero, reset for two cycles, scenarios
   initial begin
      {last_rate_data, outer_ber_ok, tp_ber_ok, stream_cont} = 4'h0;
      {early_sync_loss, tp_inverted, not_aligned, local_port} = 18'h0;
      {major1_in, major2_in, minor1_in, minor2_in, common_in} = 40'h0;
      {volt_p5, volt_p12, volt_n12_mag, volt_p24, buf_fill} = 40'h0;
      {hour, minute, second, year, month, day} = 48'h0;
      {fec_cols_l, fec_cols_d, input_level, ebno_est} = 48'h0;
      {est_ber_mant, est_ber_exp, tp_ber_mant, tp_ber_exp} = 64'h0;
      {dest_port, freq_offset, symb_offset, tp_run_time} = 112'h0;
      {local_ip, dest_ip, total_pkts, fec_pkts, port_state} = 131'h0;
      {tp_err_count, local_mac, dest_mac, revision} = 320'h0;
      ebno_qual = EBNO_INVALID;
      eth_mode = ETH_UDP;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_clock();
      t_alarm();
      t_status();
      t_eth();
      t_refuse();
      tally_and_finish();
   end
   // Watchdog against a hung handshake
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule // status_query_responder_tb
`default_nettype wire
